// ===== src/cld_cfg.svh
// Constants for the logic-op decoder: opcode patterns, fields, reset values.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CLD_CFG_SVH
`define CLD_CFG_SVH

// Field positions within the 12-bit instruction word
`define CLD_DEST_BIT     5
`define CLD_F_MSB        4
`define CLD_LIT_MSB      7

// Six-bit major patterns for register-operand instructions
`define CLD_PAT_INC      6'h0A
`define CLD_PAT_INC_SKIP 6'h0F
`define CLD_PAT_OR_REG   6'h04
`define CLD_PAT_SWAP     6'h0E
`define CLD_PAT_XOR_REG  6'h06

// Four-bit major patterns for literal instructions
`define CLD_PAT_OR_LIT   4'hD
`define CLD_PAT_XOR_LIT  4'hF

// Direction load: upper nine bits zero, low field selects the port
`define CLD_PAT_DIR_HI   9'h000
`define CLD_DIR_INDEX    3'h6

// Word executed in place of a discarded fetch
`define CLD_NOP_WORD     12'h000

// Reset values
`define CLD_ACC_RESET    8'h00
`define CLD_DIR_RESET    8'hFF
`define CLD_RF_RESET     8'h00

`endif

// ===== src/cld_pkg.sv
// Types used by the logic-op decoder core alone; its register file does not use them.
// Assumes nothing beyond a SystemVerilog compiler.
package cld_pkg;

   typedef enum logic [1:0] {
      cld_q1,
      cld_q2,
      cld_q3,
      cld_q4
   } cld_phase_e;

   typedef enum logic [3:0] {
      cld_no_op,
      cld_increment_op,
      increment_skip_on_null_op,
      or_literal_op,
      or_register_op,
      nibble_exchange_op,
      direction_register_load,
      xor_literal_op,
      xor_register_op
   } cld_op_e;

endpackage : cld_pkg

// ===== src/cld_rf_if.sv
// Read and write port between the decoder core and its data register file.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface cld_rf_if #(
   parameter int AW = 5,
   parameter int DW = 8
);
   logic          rd_en;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;

   modport core (
      output rd_en,
      output rd_addr,
      input  rd_data,
      output wr_en,
      output wr_addr,
      output wr_data
   );

   modport mem (
      input  rd_en,
      input  rd_addr,
      output rd_data,
      input  wr_en,
      input  wr_addr,
      input  wr_data
   );
endinterface : cld_rf_if

// ===== src/cld_regfile.sv
// Data register file, one read and one write port, registered read data.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps
`include "cld_cfg.svh"
module cld_regfile #(
   parameter int AW    = 5,
   parameter int DW    = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rstn,
   cld_rf_if.mem    rf
);
   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] rd_data_q;

   if (DEPTH != (1 << AW) || DW != 8) begin : g_bad_size
      $error("cld_regfile: DEPTH must equal 2**AW and DW must be 8");
   end

   // Cleared at reset so every operand is known
   always_ff @(posedge clock) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= `CLD_RF_RESET;
         end
      end else if (rf.wr_en) begin
         mem_q[rf.wr_addr] <= rf.wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rd_data_q <= `CLD_RF_RESET;
      end else if (rf.rd_en) begin
         rd_data_q <= mem_q[rf.rd_addr];
      end
   end

   assign rf.rd_data = rd_data_q;
endmodule : cld_regfile

// ===== src/cld_core.sv
// Decoder and executor for the increment, OR, XOR, swap and direction-load ops.
// Assumes the fetch path holds the next instruction word steady during phase 1.
//
// Overview of operation
// - Five-bit field picks register; target bit 0 to accumulator, 1 to register.
// - Increment register, route by target bit, update null flag only; one cycle.
// - Increment register, no flags; zero result discards next fetch, runs nop.
// - OR accumulator with 8-bit literal into accumulator, update null flag.
// - OR accumulator with register, route by target bit, update null flag.
// - Swap register nibbles, route by target bit, flags untouched.
// - Low field 6 copies accumulator into direction register, flags untouched.
// - XOR accumulator with 8-bit literal into accumulator, update null flag.
// - XOR accumulator with register, route by target bit, update null flag.
// - Operand read in phase two, destination written in phase four.
// - Eight-bit accumulator, not reachable through register file addresses.
`timescale 1ns/1ps
`include "cld_cfg.svh"
module cld_core #(
   parameter int AW = 5
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [11:0] instr_word,
   output logic [1:0]       phase_q,
   output logic [7:0]       acc_q,
   output logic             null_flag_q,
   output logic [7:0]       dir_q,
   output logic             skip_q,
   output logic             rf_wr_en_q,
   output logic [AW-1:0]    rf_wr_addr_q,
   output logic [7:0]       rf_wr_data_q
);
   cld_pkg::cld_phase_e phase_st_q;
   cld_pkg::cld_op_e    op;
   logic [11:0]         ir_q;
   logic [7:0]          res;
   logic [7:0]          lit;
   logic                to_reg;
   logic                to_acc;
   logic                flag_op;
   logic                reg_op;
   logic                exec;

   if (AW != `CLD_F_MSB + 1) begin : g_bad_aw
      $error("cld_core: AW must match the five-bit register field");
   end

   cld_rf_if #(.AW(AW), .DW(8)) rf ();

   cld_regfile #(.AW(AW), .DW(8), .DEPTH(1 << AW)) u_rf (
      .clock (clock),
      .rstn  (rstn),
      .rf    (rf)
   );

   assign lit  = ir_q[`CLD_LIT_MSB:0];
   assign exec = (phase_st_q == cld_pkg::cld_q4);

   // Four phases per instruction cycle
   always_ff @(posedge clock) begin
      if (!rstn) begin
         phase_st_q <= cld_pkg::cld_q1;
      end else begin
         case (phase_st_q)
            cld_pkg::cld_q1: phase_st_q <= cld_pkg::cld_q2;
            cld_pkg::cld_q2: phase_st_q <= cld_pkg::cld_q3;
            cld_pkg::cld_q3: phase_st_q <= cld_pkg::cld_q4;
            default:         phase_st_q <= cld_pkg::cld_q1;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= 2'(phase_st_q + 2'h1);
      end
   end

   // Latch in phase 1; a pending skip swaps the fetch for a nop
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ir_q <= `CLD_NOP_WORD;
      end else if (phase_st_q == cld_pkg::cld_q1) begin
         ir_q <= skip_q ? `CLD_NOP_WORD : instr_word;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         skip_q <= 1'b0;
      end else if (exec) begin
         skip_q <= (op == cld_pkg::increment_skip_on_null_op) && (res == 8'h00);
      end
   end

   // Decode; anything outside this subset executes as a nop here
   always_comb begin
      op = cld_pkg::cld_no_op;
      if (ir_q[11:6] == `CLD_PAT_INC) begin
         op = cld_pkg::cld_increment_op;
      end else if (ir_q[11:6] == `CLD_PAT_INC_SKIP) begin
         op = cld_pkg::increment_skip_on_null_op;
      end else if (ir_q[11:6] == `CLD_PAT_OR_REG) begin
         op = cld_pkg::or_register_op;
      end else if (ir_q[11:6] == `CLD_PAT_SWAP) begin
         op = cld_pkg::nibble_exchange_op;
      end else if (ir_q[11:6] == `CLD_PAT_XOR_REG) begin
         op = cld_pkg::xor_register_op;
      end else if (ir_q[11:8] == `CLD_PAT_OR_LIT) begin
         op = cld_pkg::or_literal_op;
      end else if (ir_q[11:8] == `CLD_PAT_XOR_LIT) begin
         op = cld_pkg::xor_literal_op;
      end else if (ir_q[11:3] == `CLD_PAT_DIR_HI && ir_q[2:0] == `CLD_DIR_INDEX) begin
         op = cld_pkg::direction_register_load;
      end
   end

   // Result from the operand read back in phase 2
   always_comb begin
      res = acc_q;
      case (op)
         cld_pkg::cld_increment_op:          res = 8'(rf.rd_data + 8'h01);
         cld_pkg::increment_skip_on_null_op: res = 8'(rf.rd_data + 8'h01);
         cld_pkg::or_literal_op:             res = acc_q | lit;
         cld_pkg::or_register_op:            res = acc_q | rf.rd_data;
         cld_pkg::nibble_exchange_op:        res = {rf.rd_data[3:0], rf.rd_data[7:4]};
         cld_pkg::xor_literal_op:            res = acc_q ^ lit;
         cld_pkg::xor_register_op:           res = acc_q ^ rf.rd_data;
         default:                            res = acc_q;
      endcase
   end

   always_comb begin
      reg_op = (op == cld_pkg::cld_increment_op) || (op == cld_pkg::increment_skip_on_null_op)
            || (op == cld_pkg::or_register_op) || (op == cld_pkg::nibble_exchange_op)
            || (op == cld_pkg::xor_register_op);
      to_reg = reg_op && ir_q[`CLD_DEST_BIT];
      to_acc = (reg_op && !ir_q[`CLD_DEST_BIT]) || (op == cld_pkg::or_literal_op)
            || (op == cld_pkg::xor_literal_op);
      flag_op = (op == cld_pkg::cld_increment_op) || (op == cld_pkg::or_literal_op)
             || (op == cld_pkg::or_register_op) || (op == cld_pkg::xor_literal_op)
             || (op == cld_pkg::xor_register_op);
   end

   // Operand read in phase 2, write-back in phase 4
   assign rf.rd_en   = (phase_st_q == cld_pkg::cld_q2);
   assign rf.rd_addr = ir_q[`CLD_F_MSB:0];
   assign rf.wr_en   = exec && to_reg;
   assign rf.wr_addr = ir_q[`CLD_F_MSB:0];
   assign rf.wr_data = res;

   // Mirror of the write port so the partner sees every store
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rf_wr_en_q   <= 1'b0;
         rf_wr_addr_q <= '0;
         rf_wr_data_q <= 8'h00;
      end else begin
         rf_wr_en_q   <= rf.wr_en;
         rf_wr_addr_q <= rf.wr_addr;
         rf_wr_data_q <= rf.wr_data;
      end
   end

   // Held apart from the register file so no address can reach it
   always_ff @(posedge clock) begin
      if (!rstn) begin
         acc_q <= `CLD_ACC_RESET;
      end else if (exec && to_acc) begin
         acc_q <= res;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         null_flag_q <= 1'b0;
      end else if (exec && flag_op) begin
         null_flag_q <= (res == 8'h00);
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         dir_q <= `CLD_DIR_RESET;
      end else if (exec && op == cld_pkg::direction_register_load) begin
         dir_q <= acc_q;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   property p_read_phase;
      rf.rd_en |-> (phase_st_q == cld_pkg::cld_q2) ##2 (phase_st_q == cld_pkg::cld_q4);
   endproperty
   a_read_phase: assert property (p_read_phase) else $error("read outside phase 2");

   property p_write_phase;
      rf_wr_en_q |-> (phase_st_q == cld_pkg::cld_q1) && $past(phase_st_q == cld_pkg::cld_q4);
   endproperty
   a_write_phase: assert property (p_write_phase) else $error("write outside phase 4");

   property p_dest_acc;
      exec && reg_op && !ir_q[`CLD_DEST_BIT] |=> !rf_wr_en_q && acc_q == $past(res);
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("target 0 misrouted");

   property p_dest_reg;
      exec && reg_op && ir_q[`CLD_DEST_BIT]
      |=> rf_wr_en_q && rf_wr_addr_q == $past(rf.rd_addr) && acc_q == $past(acc_q);
   endproperty
   a_dest_reg: assert property (p_dest_reg) else $error("target 1 misrouted");

   property p_null_flag;
      exec && flag_op |=> null_flag_q == ($past(res) == 8'h00);
   endproperty
   a_null_flag: assert property (p_null_flag) else $error("null flag wrong");

   property p_flag_kept;
      exec && !flag_op |=> $stable(null_flag_q);
   endproperty
   a_flag_kept: assert property (p_flag_kept) else $error("null flag disturbed");

   property p_or_literal;
      exec && op == cld_pkg::or_literal_op |=> acc_q == ($past(acc_q) | $past(lit));
   endproperty
   a_or_literal: assert property (p_or_literal) else $error("or literal wrong");

   property p_xor_literal;
      exec && op == cld_pkg::xor_literal_op |=> acc_q == ($past(acc_q) ^ $past(lit));
   endproperty
   a_xor_literal: assert property (p_xor_literal) else $error("xor literal wrong");

   property p_skip_nop;
      exec && op == cld_pkg::increment_skip_on_null_op && rf.rd_data == 8'hFF
      |=> skip_q ##1 (ir_q == `CLD_NOP_WORD) [*4];
   endproperty
   a_skip_nop: assert property (p_skip_nop) else $error("skip did not insert nop");

   property p_dir_load;
      exec && op == cld_pkg::direction_register_load
      |=> dir_q == $past(acc_q) && $stable(acc_q);
   endproperty
   a_dir_load: assert property (p_dir_load) else $error("direction load wrong");

endmodule : cld_core

// ===== tb/cld_fetch_model.sv
// Fetch path model: hands one queued word to the core per instruction cycle.
// Assumes the core takes instr_word at the edge that ends phase 1.
`timescale 1ns/1ps
module cld_fetch_model (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [1:0]  phase_q,
   output logic      [11:0] instr_word
);
   logic [11:0] word_q [$];
   logic        taken;

   task automatic push(input logic [11:0] w);
      word_q.push_back(w);
   endtask : push

   initial instr_word = 12'h000;

   // Outside phase 1 the word toggles, so a sample in the wrong phase shows
   always @(posedge clock) begin
      taken = rstn && phase_q == 2'h0;
      #1;
      if (taken && word_q.size() > 0) begin
         void'(word_q.pop_front());
      end
      if (phase_q != 2'h0) begin
         instr_word = ~instr_word;
      end else begin
         instr_word = (word_q.size() > 0) ? word_q[0] : 12'h000;
      end
   end
endmodule : cld_fetch_model

// ===== tb/tb.sv
// Self-checking bench for the logic-op core, directed then random words.
// Assumes the core and its register file are reset by one synchronous rstn.
`timescale 1ns/1ps
`include "cld_cfg.svh"
module tb;
   typedef struct packed {
      logic [7:0] acc;
      logic       z;
      logic [7:0] dir;
      logic       skip;
      logic       wr;
      logic [4:0] addr;
      logic [7:0] data;
   } cld_note_s;

   logic        clock;
   logic        rstn;
   logic [11:0] instr_word;
   logic [1:0]  phase_q;
   logic [7:0]  acc_q;
   logic        null_flag_q;
   logic [7:0]  dir_q;
   logic        skip_q;
   logic        rf_wr_en_q;
   logic [4:0]  rf_wr_addr_q;
   logic [7:0]  rf_wr_data_q;
   int          n_mismatch;
   int          n_compared;
   int          seed;
   cld_note_s   note_q [$];
   cld_note_s   nt;
   logic [7:0]  m_rf [32];
   logic [7:0]  m_acc;
   logic [7:0]  m_dir;
   logic        m_z;
   logic        m_skip;
   logic [7:0]  exp_acc;
   logic        was4;
   logic [1:0]  exp_ph;
   logic [31:0] r;
   logic [4:0]  f;
   logic [11:0] w;
   // Zero results, a skipped OR literal, a non-direction low field, swap and OR
   logic [11:0] prog [17] = '{12'hFFF, 12'h1BF, 12'h29F, 12'h3FF, 12'hDFF, 12'h3FF,
      12'h006, 12'h005, 12'hF5A, 12'h006, 12'h39F, 12'h13F, 12'hFEF, 12'h1A0,
      12'h3C0, 12'h3C0, 12'hD00};

   cld_core cld_core_inst (
      .clock        (clock),
      .rstn         (rstn),
      .instr_word   (instr_word),
      .phase_q      (phase_q),
      .acc_q        (acc_q),
      .null_flag_q  (null_flag_q),
      .dir_q        (dir_q),
      .skip_q       (skip_q),
      .rf_wr_en_q   (rf_wr_en_q),
      .rf_wr_addr_q (rf_wr_addr_q),
      .rf_wr_data_q (rf_wr_data_q)
   );

   cld_fetch_model cld_fetch_model_inst (
      .clock      (clock),
      .rstn       (rstn),
      .phase_q    (phase_q),
      .instr_word (instr_word)
   );

   always #50 clock = ~clock;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   // Reference step; a pending skip turns the fetched word into a nop
   task automatic exec(input logic [11:0] wd);
      logic [11:0] x;
      logic [7:0]  src;
      logic [7:0]  res;
      logic        upz;
      logic        reg_op;
      cld_note_s   n;
      x = m_skip ? `CLD_NOP_WORD : wd;
      src = m_rf[x[`CLD_F_MSB:0]];
      res = 8'h00;
      upz = 1'b1;
      reg_op = 1'b1;
      n = '0;
      case (x[11:6])
         `CLD_PAT_INC: res = src + 8'h01;
         `CLD_PAT_INC_SKIP: begin
            res = src + 8'h01;
            upz = 1'b0;
         end
         `CLD_PAT_OR_REG: res = m_acc | src;
         `CLD_PAT_SWAP: begin
            res = {src[3:0], src[7:4]};
            upz = 1'b0;
         end
         `CLD_PAT_XOR_REG: res = m_acc ^ src;
         default: reg_op = 1'b0;
      endcase
      m_skip = x[11:6] == `CLD_PAT_INC_SKIP && res == 8'h00;
      if (!reg_op) begin
         case (x[11:8])
            `CLD_PAT_OR_LIT: res = m_acc | x[7:0];
            `CLD_PAT_XOR_LIT: res = m_acc ^ x[7:0];
            default: upz = 1'b0;
         endcase
         if (x[11:3] == `CLD_PAT_DIR_HI && x[2:0] == `CLD_DIR_INDEX) begin
            m_dir = m_acc;
         end
         if (upz) begin
            m_acc = res;
         end
      end else if (x[`CLD_DEST_BIT]) begin
         m_rf[x[4:0]] = res;
         n.wr = 1'b1;
         n.addr = x[4:0];
         n.data = res;
      end else begin
         m_acc = res;
      end
      if (upz) begin
         m_z = res == 8'h00;
      end
      n.acc = m_acc;
      n.z = m_z;
      n.dir = m_dir;
      n.skip = m_skip;
      note_q.push_back(n);
      cld_fetch_model_inst.push(wd);
   endtask : exec

   // Results land at the edge that ends phase 4; nothing moves in between
   always @(posedge clock) begin
      was4 = rstn && phase_q == 2'h3;
      // Own phase count, so a stuck or skipping phase shows
      exp_ph = rstn ? 2'(exp_ph + 2'h1) : 2'h0;
      #2;
      if (was4 && note_q.size() > 0) begin
         nt = note_q.pop_front();
         exp_acc = nt.acc;
         check({7'h00, null_flag_q}, {7'h00, nt.z});
         check(dir_q, nt.dir);
         check({7'h00, skip_q}, {7'h00, nt.skip});
         check({7'h00, rf_wr_en_q}, {7'h00, nt.wr});
         if (nt.wr) begin
            check({3'h0, rf_wr_addr_q}, {3'h0, nt.addr});
            check(rf_wr_data_q, nt.data);
         end
      end else if (rstn) begin
         check({7'h00, rf_wr_en_q}, 8'h00);
      end
      if (rstn) begin
         check(acc_q, exp_acc);
         check({6'h00, phase_q}, {6'h00, exp_ph});
      end
   end

   initial begin
      #2_000_000;
      n_mismatch++;
      complete_run();
   end

   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      seed = 32'hf804_ff81;
      m_acc = `CLD_ACC_RESET;
      m_dir = `CLD_DIR_RESET;
      m_z = 1'b0;
      m_skip = 1'b0;
      exp_acc = `CLD_ACC_RESET;
      foreach (m_rf[i]) m_rf[i] = `CLD_RF_RESET;
      foreach (prog[i]) exec(prog[i]);
      // Few registers, both ends of the index range, so results interact
      for (int i = 0; i < 100; i++) begin
         r = $random(seed);
         f = {r[20], r[20], r[20], r[13:12]};
         case (r[3:0])
            4'h0: w = {`CLD_PAT_INC, r[5], f};
            4'h1: w = {`CLD_PAT_INC_SKIP, r[5], f};
            4'h2: w = {`CLD_PAT_OR_REG, r[5], f};
            4'h3: w = {`CLD_PAT_SWAP, r[5], f};
            4'h4, 4'h5: w = {`CLD_PAT_XOR_REG, r[5], f};
            4'h6: w = {`CLD_PAT_OR_LIT, r[11:4]};
            4'h7, 4'h8: w = {`CLD_PAT_XOR_LIT, r[11:4]};
            4'h9: w = {`CLD_PAT_DIR_HI, `CLD_DIR_INDEX};
            default: w = r[27:16];
         endcase
         exec(w);
      end
      repeat (2) @(posedge clock);
      #1;
      check(acc_q, `CLD_ACC_RESET);
      check(dir_q, `CLD_DIR_RESET);
      check({4'h0, phase_q, null_flag_q, skip_q}, 8'h00);
      rstn = 1'b1;
      for (int i = 0; i < 2000 && note_q.size() > 0; i++) @(posedge clock);
      if (note_q.size() > 0) begin
         n_mismatch++;
      end
      complete_run();
   end
endmodule : tb
